// ---- rtl/sfp_pkg.sv ----
/*
 Package for the socket force and power control block: offsets, field positions, reset values.
 Assumes a single clock domain and the plain register port of the block.
*/
`default_nettype none
package sfp_pkg;
	// Register offsets (byte addresses)
	localparam logic [7:0] FORCE_OFS = 8'h0C;
	localparam logic [7:0] CTRL_OFS = 8'h10;
	localparam logic [7:0] STATE_OFS = 8'h08;
	localparam logic [7:0] INT_STAT_OFS = 8'h20;
	localparam logic [7:0] INT_EN_OFS = 8'h24;
	localparam logic [7:0] INT_CLR_OFS = 8'h28;
	// Force register bit positions
	localparam int F_NOTCARD = 7;
	localparam int F_DATALOST = 8;
	localparam int F_BADVCC = 9;
	localparam int F_5V = 10;
	localparam int F_3V = 11;
	localparam int F_RETEST = 14;
	localparam int F_VIDEO = 27;
	// Present state bit positions
	localparam int S_NOTCARD = 7;
	localparam int S_DATALOST = 8;
	localparam int S_BADVCC = 9;
	localparam int S_5V = 10;
	localparam int S_3V = 11;
	localparam int S_LOCK = 13;
	localparam int S_BUSY = 14;
	localparam int S_CARD = 15;
	localparam int S_VIDEO = 27;
	// Control register fields
	localparam int C_CORE_LSB = 0;
	localparam int C_MAIN_LSB = 4;
	localparam int C_CORE_W = 3;
	localparam int C_MAIN_W = 3;
	// Interrupt status bits
	localparam int I_INSERT = 0;
	localparam int I_DETDONE = 1;
	localparam int I_LOCK = 2;
	localparam int I_W = 3;
	// Reset values and counts
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	localparam logic [2:0] DET_CYCLES = 3'h4;
	typedef enum logic [1:0] {DET_IDLE, DET_WAIT, DET_LATCH} sfp_det_t;
endpackage
`default_nettype wire

// ---- rtl/sfp_socket_ctrl.sv ----
/*
 Socket force and socket control registers with voltage detection and interrupts.
 Assumes a plain register port synchronous to core_clk_i; sense and detect lines are synchronous.
*/
`default_nettype none
module sfp_socket_ctrl (
	// Clock, reset, enable
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Socket lines
	input wire logic [1:0] voltage_sense_lines_i,
	input wire logic [1:0] card_detect_lines_i,
	// Supply switch outputs
	output logic [2:0] main_supply_o,
	output logic [2:0] core_supply_o,
	// Interrupt
	output logic irq_o
);
	localparam int I_W_LOC = sfp_pkg::I_W;
	logic [31:0] state_ff;
	logic [5:0] ctrl_ff;
	logic lock_ff;
	logic [I_W_LOC-1:0] ist_ff;
	logic [I_W_LOC-1:0] ien_ff;
	logic card_ff;
	logic [2:0] det_cnt_ff;
	logic [31:0] rdata_ff;
	sfp_pkg::sfp_det_t det_ff;

	logic card_now;
	logic wr_force;
	logic wr_ctrl;
	logic start_det;
	logic det_done;
	logic insert_evt;
	logic lock_evt;
	logic [31:0] fw;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	assign card_now = (card_detect_lines_i == 2'h0);
	assign fw = wdata_i;
	assign wr_force = wr_i && hit(addr_i, sfp_pkg::FORCE_OFS);
	assign wr_ctrl = wr_i && hit(addr_i, sfp_pkg::CTRL_OFS);
	assign insert_evt = card_now && !card_ff;
	assign start_det = (wr_force && fw[sfp_pkg::F_RETEST]) || insert_evt;
	assign det_done = (det_ff == sfp_pkg::DET_LATCH);
	assign lock_evt = wr_force && (fw[sfp_pkg::F_5V] || fw[sfp_pkg::F_3V]);

	// Card presence tracking
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			card_ff <= 1'b0;
		end else if (ce_i) begin
			card_ff <= card_now;
		end
	end

	// Detection sequence
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			det_ff <= sfp_pkg::DET_IDLE;
			det_cnt_ff <= 3'h0;
		end else if (ce_i) begin
			case (det_ff)
				sfp_pkg::DET_IDLE: begin
					if (start_det) begin
						det_ff <= sfp_pkg::DET_WAIT;
						det_cnt_ff <= sfp_pkg::DET_CYCLES;
					end
				end
				sfp_pkg::DET_WAIT: begin
					if (det_cnt_ff == 3'h1) begin
						det_ff <= sfp_pkg::DET_LATCH;
					end
					det_cnt_ff <= det_cnt_ff - 3'h1;
				end
				sfp_pkg::DET_LATCH: begin
					det_ff <= sfp_pkg::DET_IDLE;
				end
				default: begin
					det_ff <= sfp_pkg::DET_IDLE;
				end
			endcase
		end
	end

	// Power-up lockout
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			lock_ff <= 1'b0;
		end else if (ce_i) begin
			if (lock_evt) begin
				lock_ff <= 1'b1;
			end else if (det_done) begin
				lock_ff <= 1'b0;
			end
		end
	end

	// Present state flags set by force writes and detection
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state_ff <= sfp_pkg::ZERO32;
		end else if (ce_i) begin
			if (det_done) begin
				state_ff[sfp_pkg::S_5V] <= !voltage_sense_lines_i[0];
				state_ff[sfp_pkg::S_3V] <= 1'b1;
				state_ff[sfp_pkg::S_NOTCARD] <= !card_now;
			end
			if (wr_force) begin
				if (fw[sfp_pkg::F_NOTCARD] && !card_now) begin
					state_ff[sfp_pkg::S_NOTCARD] <= 1'b1;
				end
				if (fw[sfp_pkg::F_DATALOST]) begin
					state_ff[sfp_pkg::S_DATALOST] <= 1'b1;
				end
				if (fw[sfp_pkg::F_BADVCC]) begin
					state_ff[sfp_pkg::S_BADVCC] <= 1'b1;
				end
				if (fw[sfp_pkg::F_5V]) begin
					state_ff[sfp_pkg::S_5V] <= 1'b1;
				end
				if (fw[sfp_pkg::F_3V]) begin
					state_ff[sfp_pkg::S_3V] <= 1'b1;
				end
				state_ff[sfp_pkg::S_VIDEO] <= fw[sfp_pkg::F_VIDEO];
			end
		end
	end

	// Socket control register
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ctrl_ff <= 6'h00;
		end else if (ce_i && wr_ctrl) begin
			ctrl_ff[2:0] <= wdata_i[sfp_pkg::C_CORE_LSB +: sfp_pkg::C_CORE_W];
			ctrl_ff[5:3] <= wdata_i[sfp_pkg::C_MAIN_LSB +: sfp_pkg::C_MAIN_W];
		end
	end

	// Supply outputs held off while locked
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			main_supply_o <= 3'h0;
			core_supply_o <= 3'h0;
		end else if (ce_i) begin
			main_supply_o <= lock_ff ? 3'h0 : ctrl_ff[5:3];
			core_supply_o <= lock_ff ? 3'h0 : ctrl_ff[2:0];
		end
	end

	// Interrupt status, enable and clear; set wins over clear
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			ist_ff <= '0;
			ien_ff <= '0;
		end else if (ce_i) begin
			if (wr_i && hit(addr_i, sfp_pkg::INT_EN_OFS)) begin
				ien_ff <= wdata_i[I_W_LOC-1:0];
			end
			ist_ff <= (ist_ff & ~((wr_i && hit(addr_i, sfp_pkg::INT_CLR_OFS)) ? wdata_i[I_W_LOC-1:0] : '0))
				| {lock_evt, det_done, insert_evt};
		end
	end

	assign irq_o = |(ist_ff & ien_ff);

	// Read data, one cycle after the strobe
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rdata_ff <= sfp_pkg::ZERO32;
		end else if (ce_i) begin
			rdata_ff <= sfp_pkg::ZERO32;
			if (rd_i) begin
				if (hit(addr_i, sfp_pkg::CTRL_OFS)) begin
					rdata_ff[sfp_pkg::C_CORE_LSB +: sfp_pkg::C_CORE_W] <= ctrl_ff[2:0];
					rdata_ff[sfp_pkg::C_MAIN_LSB +: sfp_pkg::C_MAIN_W] <= ctrl_ff[5:3];
				end else if (hit(addr_i, sfp_pkg::STATE_OFS)) begin
					rdata_ff <= state_ff;
					rdata_ff[sfp_pkg::S_LOCK] <= lock_ff;
					rdata_ff[sfp_pkg::S_BUSY] <= (det_ff != sfp_pkg::DET_IDLE);
					rdata_ff[sfp_pkg::S_CARD] <= card_now;
				end else if (hit(addr_i, sfp_pkg::INT_STAT_OFS)) begin
					rdata_ff[I_W_LOC-1:0] <= ist_ff;
				end else if (hit(addr_i, sfp_pkg::INT_EN_OFS)) begin
					rdata_ff[I_W_LOC-1:0] <= ien_ff;
				end
			end
		end
	end

	assign rdata_o = rdata_ff;
endmodule
`default_nettype wire

// ---- testbench/sfp_chk_assertions.sv ----
/* Checker on the ports of sfp_socket_ctrl; assumes ce_i stays high. */
`default_nettype none
module sfp_chk (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic [2:0] main_supply_o,
	input wire logic [2:0] core_supply_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] ra_ff;
	logic [1:0] flag_ff;
	wire fw = wr_i && addr_i == 8'h0C;
	always_ff @(posedge core_clk_i) begin
		ra_ff <= (rst_i || !rd_i) ? 8'hFF : addr_i;
		if (rst_i) flag_ff <= 2'h0;
		else if (fw) flag_ff <= {wdata_i[27], flag_ff[0] | wdata_i[8]};
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	idle_rdata_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0) else $error("stray data");
	force_rd_a: assert property (ra_ff == 8'h0C |-> rdata_o == 32'h0) else $error("force data");
	unmapped_rd_a: assert property (ra_ff == 8'h04 |-> rdata_o == 32'h0) else $error("unmapped data");
	state_rsvd_a: assert property (ra_ff == 8'h08 |-> rdata_o[26:16] == 11'h0) else $error("reserved set");
	video_flag_a: assert property (ra_ff == 8'h08 |-> rdata_o[27] == flag_ff[1]) else $error("video flag");
	lost_flag_a: assert property (ra_ff == 8'h08 |-> rdata_o[8] == flag_ff[0]) else $error("lost flag");
	supply_lock_a: assert property (fw && |wdata_i[11:10] |-> ##3 {main_supply_o, core_supply_o} == 6'h0)
		else $error("supply on");
	reset_clear_a: assert property ($fell(rst_i) |-> {rdata_o, main_supply_o, core_supply_o} == 38'h0)
		else $error("reset values");
endmodule
bind sfp_socket_ctrl sfp_chk u_sfp_chk (.core_clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
	.main_supply_o, .core_supply_o);
`default_nettype wire

// ---- testbench/sfp_card.sv ----
/* Card model on the socket lines; assumes pull-ups hold the lines high when empty. */
`default_nettype none
module sfp_card (
	input wire logic present_i,
	output logic [1:0] vs_o,
	output logic [1:0] cd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	assign cd_o = present_i ? 2'h0 : 2'h3;
	assign vs_o = present_i ? 2'h2 : 2'h3;
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
/* Bench for sfp_socket_ctrl; assumes the card model and the bound checker. */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, present = 0, irq_o, ce = 1;
	logic [7:0] addr_i = 8'h0;
	logic [31:0] wdata_i = 32'h0, rdata_o;
	logic [2:0] main_supply_o, core_supply_o;
	logic [1:0] vs, cd;
	int errors = 0, n_compared = 0;
	sfp_socket_ctrl u_sfp_socket_ctrl (.core_clk_i, .rst_i, .ce_i(ce), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.voltage_sense_lines_i(vs), .card_detect_lines_i(cd), .main_supply_o, .core_supply_o, .irq_o);
	sfp_card u_sfp_card (.present_i(present), .vs_o(vs), .cd_o(cd));
	initial forever #4 core_clk_i = ~core_clk_i;
	task automatic ck(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		errors += int'(g !== e);
		if (g !== e) $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
	endtask
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
		{wr_i, rd_i, addr_i, wdata_i} <= {w, r, a, d};
		@(posedge core_clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b0, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
		bus(1'b0, 1'b1, a, 32'h0);
		#1 ck(rdata_o & m, e);
		bus(1'b0, 1'b0, a, 32'h0);
	endtask
	task automatic st(input logic [31:0] e);
		#1 ck({25'h0, irq_o, main_supply_o, core_supply_o}, e);
	endtask
	task automatic t_reset(input int n);
		rst_i <= 1'b1;
		repeat (n) @(posedge core_clk_i);
		rst_i <= 1'b0;
		rd(8'h10, 32'h0);
		st(32'h0);
	endtask
	task automatic t_regs;
		wr(8'h0C, 32'hF7FF_B040);
		rd(8'h08, 32'h0, 32'h800_0FC0);
		rd(8'h0C, 32'h0);
		rd(8'h04, 32'h0);
		wr(8'h0C, 32'h800_0000);
		rd(8'h08, 32'h800_0000, 32'h800_0FC0);
	endtask
	task automatic t_card;
		wr(8'h0C, 32'h80);
		rd(8'h08, 32'h80, 32'h8080);
		present <= 1'b1;
		repeat (12) @(posedge core_clk_i);
		rd(8'h08, 32'h8000, 32'h8080);
		wr(8'h0C, 32'h80);
		rd(8'h08, 32'h0, 32'h80);
	endtask
	task automatic t_power;
		wr(8'h10, 32'h35);
		rd(8'h10, 32'h35);
		st(32'h1D);
		wr(8'h0C, 32'h400);
		rd(8'h08, 32'h2400, 32'h2400);
		st(32'h0);
		wr(8'h24, 32'h4);
		st(32'h40);
		wr(8'h28, 32'h4);
		st(32'h0);
		wr(8'h0C, 32'h4000);
		repeat (10) @(posedge core_clk_i);
		rd(8'h08, 32'hC00, 32'h6C00);
		wr(8'h0C, 32'h800);
		wr(8'h0C, 32'h300);
		rd(8'h08, 32'h2B00, 32'h2B00);
	endtask
	task automatic t_freeze;
		ce <= 1'b0;
		wr(8'h10, 32'h11);
		ce <= 1'b1;
		rd(8'h10, 32'h35);
	endtask
	task automatic tally_and_finish;
		if (errors == 0 && n_compared > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		t_reset(8);
		t_regs();
		t_card();
		t_power();
		t_freeze();
		t_reset(2);
		tally_and_finish();
	end
	initial begin
		#20000 errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
